// ---- pkg/tch_consts.svh ----
`ifndef TCH_CONSTS_SVH
`define TCH_CONSTS_SVH

// Register offsets inside the expanded register bank.
`define TCH_OFS_TIMER8_LO_HOLD   4'h4
`define TCH_OFS_TIMER8_HI_HOLD   4'h5
`define TCH_OFS_TIMER16_LO_HOLD  4'h6
`define TCH_OFS_TIMER16_HI_HOLD  4'h7
`define TCH_OFS_TIMER16_CAP_LO   4'h8
`define TCH_OFS_TIMER16_CAP_HI   4'h9
`define TCH_OFS_TIMER8_CAP_LO    4'hA
`define TCH_OFS_TIMER8_CAP_HI    4'hB

// Field positions of the sixteen-bit values.
`define TCH_TIMER16_HI_MSB 15
`define TCH_TIMER16_HI_LSB 8
`define TCH_TIMER16_LO_MSB 7
`define TCH_TIMER16_LO_LSB 0

// Reset values and the answer for addresses this block does not own.
`define TCH_RST_BYTE  8'h00
`define TCH_RST_WORD  16'h0000
`define TCH_UNMAPPED  8'h00

// Pin change to capture strobe, in system clock cycles.
`define TCH_EDGE_LATENCY 3

`endif

// ---- pkg/tch_pkg.sv ----
package tch_pkg;
  // One register byte and the register address within the bank.
  typedef logic [7:0] tch_byte_t;
  typedef logic [3:0] tch_addr_t;
  // Edge selection in demodulation mode, in field order.
  typedef enum logic [1:0] {
    TCH_EDGE_FALL,
    TCH_EDGE_RISE,
    TCH_EDGE_BOTH,
    TCH_EDGE_RSVD
  } tch_edge_e;
endpackage

// ---- pkg/tch_edge_if.sv ----
interface tch_edge_if;
  logic pos_edge;
  logic neg_edge;
  modport src (output pos_edge, output neg_edge);
  modport dst (input pos_edge, input neg_edge);
endinterface

// ---- hdl/tch_edge_detect.sv ----
module tch_edge_detect (
  // Clock and reset.
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  // Demodulator pins, asynchronous to the clock.
  input  wire logic pin_a_i,
  input  wire logic pin_b_i,
  input  wire logic sel_b_i,
  // Edge pulses towards the capture logic.
  tch_edge_if.src   edge_o
);
  logic [1:0] pins;
  logic [1:0] meta_q;
  logic [1:0] sync_q;
  logic       prev_q;
  logic       pos_q;
  logic       neg_q;
  wire  logic level_w;

  assign pins = {pin_b_i, pin_a_i};

  // Each pin passes two flip-flops before any logic looks at it.
  for (genvar g = 0; g < 2; g++) begin : g_sync
    always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
        meta_q[g] <= 1'b0;
        sync_q[g] <= 1'b0;
      end else begin
        meta_q[g] <= pins[g];
        sync_q[g] <= meta_q[g];
      end
    end
  end

  // Pick the monitored pin.
  assign level_w = sel_b_i ? sync_q[1] : sync_q[0];

  // Compare with the previous level and register one-cycle pulses.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      prev_q <= 1'b0;
      pos_q  <= 1'b0;
      neg_q  <= 1'b0;
    end else begin
      prev_q <= level_w;
      pos_q  <= level_w & ~prev_q;
      neg_q  <= ~level_w & prev_q;
    end
  end

  assign edge_o.pos_edge = pos_q;
  assign edge_o.neg_edge = neg_q;

  property p_pulse_excl;
    @(posedge clk_i) disable iff (!rst_b_i) !(pos_q && neg_q);
  endproperty
  a_pulse_excl: assert property (p_pulse_excl) else $error("Both edge pulses high together.");

  property p_pos_cause;
    @(posedge clk_i) disable iff (!rst_b_i) pos_q |-> $past(level_w) && !$past(prev_q);
  endproperty
  a_pos_cause: assert property (p_pos_cause) else $error("Rising pulse without a rising level.");
endmodule

// ---- hdl/tch_capture_hold.sv ----
`include "tch_consts.svh"

// What this block does
// - Falling demod edge loads eight-bit count into high-time capture register.
// - Rising demod edge loads eight-bit count into low-time capture register.
// - Sixteen-bit capture high register takes the counter's most significant byte.
// - Sixteen-bit capture low register takes the counter's least significant byte.
// - Capture registers read captured data; software writes to them are ignored.
// - Read/write high hold byte supplies upper half of sixteen-bit load value.
// - Read/write low hold byte supplies lower half of sixteen-bit load value.
// - Read/write high and low level hold registers set eight-bit counter values.
// - Low level hold register is a full separate eight-bit register.
// - Sixteen-bit hold bytes may change anytime; they act only at the next load.
// - With capture mask set, each eight-bit capture raises an interrupt request.
// - Edge detector watches one of two pins and yields rising or falling pulses.
module tch_capture_hold
  import tch_pkg::*;
#(
  parameter int BYTE_W = 8
) (
  // Clock and reset.
  input  wire logic             CLK_I,
  input  wire logic             RST_B_I,
  // Register file access from the processor core.
  input  wire tch_pkg::tch_addr_t REG_ADDR_I,
  input  wire logic             REG_WR_I,
  input  wire logic             REG_RD_I,
  input  wire tch_pkg::tch_byte_t REG_WDATA_I,
  output logic [7:0]            REG_RDATA_O,
  // Control bits from the timer control registers.
  input  wire logic             DEMOD_MODE_I,
  input  wire logic             DEMOD_SEL_B_I,
  input  wire logic [1:0]       EDGE_SEL_I,
  input  wire logic             CAPTURE_INT_MASK_I,
  // Counter cores.
  input  wire logic [7:0]       TIMER8_COUNT_I,
  input  wire logic [15:0]      TIMER16_COUNT_I,
  input  wire logic             TIMER16_ENABLE_I,
  input  wire logic             TIMER16_MODULO_I,
  input  wire logic             TIMER16_TERMINAL_I,
  output logic [15:0]           TIMER16_LOAD_VALUE_O,
  output logic                  TIMER16_LOAD_O,
  output logic [7:0]            TIMER8_HIGH_LEVEL_O,
  output logic [7:0]            TIMER8_LOW_LEVEL_O,
  // Demodulator pins and capture interrupt request.
  input  wire logic             DEMOD_PIN_A_I,
  input  wire logic             DEMOD_PIN_B_I,
  output logic                  CAPTURE_IRQ_O
);
  import tch_pkg::*;

  if (BYTE_W != 8) begin : g_check
    $error("BYTE_W must be 8.");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Edge detection.

  tch_edge_if edge_bus ();

  tch_edge_detect tch_edge_detect_i (
    .clk_i   (CLK_I),
    .rst_b_i (RST_B_I),
    .pin_a_i (DEMOD_PIN_A_I),
    .pin_b_i (DEMOD_PIN_B_I),
    .sel_b_i (DEMOD_SEL_B_I),
    .edge_o  (edge_bus.src)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Decoding.

  tch_edge_e  edge_mode;
  wire  logic rise_ok;
  wire  logic fall_ok;
  wire  logic cap_hi_w;
  wire  logic cap_lo_w;
  wire  logic cap_any_w;
  wire  logic wr_timer8_lo;
  wire  logic wr_timer8_hi;
  wire  logic wr_timer16_lo;
  wire  logic wr_timer16_hi;
  wire  logic load_w;
  logic [7:0] rd_mux;

  // Selected edges in demodulation mode; the reserved code captures nothing.
  assign edge_mode = tch_edge_e'(EDGE_SEL_I);
  assign rise_ok   = (edge_mode == TCH_EDGE_RISE) || (edge_mode == TCH_EDGE_BOTH);
  assign fall_ok   = (edge_mode == TCH_EDGE_FALL) || (edge_mode == TCH_EDGE_BOTH);
  assign cap_hi_w  = DEMOD_MODE_I && fall_ok && edge_bus.neg_edge;
  assign cap_lo_w  = DEMOD_MODE_I && rise_ok && edge_bus.pos_edge;
  assign cap_any_w = cap_hi_w || cap_lo_w;

  // Write strobes; capture offsets have none, so writes there are dropped.
  assign wr_timer8_lo  = REG_WR_I && (REG_ADDR_I == `TCH_OFS_TIMER8_LO_HOLD);
  assign wr_timer8_hi  = REG_WR_I && (REG_ADDR_I == `TCH_OFS_TIMER8_HI_HOLD);
  assign wr_timer16_lo = REG_WR_I && (REG_ADDR_I == `TCH_OFS_TIMER16_LO_HOLD);
  assign wr_timer16_hi = REG_WR_I && (REG_ADDR_I == `TCH_OFS_TIMER16_HI_HOLD);

  ////////////////////////////////////////////////////////////////////////////////
  // Registers.

  logic [7:0]  timer8_lo_hold_q;
  logic [7:0]  timer8_hi_hold_q;
  logic [7:0]  timer16_lo_hold_q;
  logic [7:0]  timer16_hi_hold_q;
  logic [7:0]  timer16_cap_lo_q;
  logic [7:0]  timer16_cap_hi_q;
  logic [7:0]  timer8_cap_lo_q;
  logic [7:0]  timer8_cap_hi_q;
  logic        en_prev_q;
  logic [15:0] load_val_q;
  logic        load_q;
  logic        irq_q;
  logic [7:0]  rdata_q;

  // Sixteen-bit load on enable rise or on terminal count in modulo-N.
  assign load_w = (TIMER16_ENABLE_I && !en_prev_q) ||
                  (TIMER16_ENABLE_I && TIMER16_MODULO_I && TIMER16_TERMINAL_I);

  // Hold registers latch write data on the clock edge.
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      timer8_lo_hold_q  <= `TCH_RST_BYTE;
      timer8_hi_hold_q  <= `TCH_RST_BYTE;
      timer16_lo_hold_q <= `TCH_RST_BYTE;
      timer16_hi_hold_q <= `TCH_RST_BYTE;
    end else begin
      if (wr_timer8_lo)  timer8_lo_hold_q  <= REG_WDATA_I;
      if (wr_timer8_hi)  timer8_hi_hold_q  <= REG_WDATA_I;
      if (wr_timer16_lo) timer16_lo_hold_q <= REG_WDATA_I;
      if (wr_timer16_hi) timer16_hi_hold_q <= REG_WDATA_I;
    end
  end

  // Capture registers change only on hardware capture events.
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      timer8_cap_hi_q  <= `TCH_RST_BYTE;
      timer8_cap_lo_q  <= `TCH_RST_BYTE;
      timer16_cap_hi_q <= `TCH_RST_BYTE;
      timer16_cap_lo_q <= `TCH_RST_BYTE;
    end else begin
      if (cap_hi_w) timer8_cap_hi_q <= TIMER8_COUNT_I;
      if (cap_lo_w) timer8_cap_lo_q <= TIMER8_COUNT_I;
      if (cap_any_w) begin
        timer16_cap_hi_q <= TIMER16_COUNT_I[`TCH_TIMER16_HI_MSB:`TCH_TIMER16_HI_LSB];
        timer16_cap_lo_q <= TIMER16_COUNT_I[`TCH_TIMER16_LO_MSB:`TCH_TIMER16_LO_LSB];
      end
    end
  end

  // Load value is sampled from the hold bytes only at a load.
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      en_prev_q  <= 1'b0;
      load_val_q <= `TCH_RST_WORD;
      load_q     <= 1'b0;
      irq_q      <= 1'b0;
    end else begin
      en_prev_q <= TIMER16_ENABLE_I;
      load_q    <= load_w;
      if (load_w) load_val_q <= {timer16_hi_hold_q, timer16_lo_hold_q};
      irq_q     <= cap_any_w && CAPTURE_INT_MASK_I;
    end
  end

  // Read data selection; capture registers return their captured bytes.
  assign rd_mux = (REG_ADDR_I == `TCH_OFS_TIMER8_LO_HOLD)  ? timer8_lo_hold_q  :
                  (REG_ADDR_I == `TCH_OFS_TIMER8_HI_HOLD)  ? timer8_hi_hold_q  :
                  (REG_ADDR_I == `TCH_OFS_TIMER16_LO_HOLD) ? timer16_lo_hold_q :
                  (REG_ADDR_I == `TCH_OFS_TIMER16_HI_HOLD) ? timer16_hi_hold_q :
                  (REG_ADDR_I == `TCH_OFS_TIMER16_CAP_LO)  ? timer16_cap_lo_q  :
                  (REG_ADDR_I == `TCH_OFS_TIMER16_CAP_HI)  ? timer16_cap_hi_q  :
                  (REG_ADDR_I == `TCH_OFS_TIMER8_CAP_LO)   ? timer8_cap_lo_q   :
                  (REG_ADDR_I == `TCH_OFS_TIMER8_CAP_HI)   ? timer8_cap_hi_q   :
                  `TCH_UNMAPPED;

  // Read answer is registered and holds until the next read.
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      rdata_q <= `TCH_RST_BYTE;
    end else if (REG_RD_I) begin
      rdata_q <= rd_mux;
    end
  end

  assign REG_RDATA_O          = rdata_q;
  assign TIMER16_LOAD_VALUE_O = load_val_q;
  assign TIMER16_LOAD_O       = load_q;
  assign TIMER8_HIGH_LEVEL_O  = timer8_hi_hold_q;
  assign TIMER8_LOW_LEVEL_O   = timer8_lo_hold_q;
  assign CAPTURE_IRQ_O        = irq_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.

  property p_cap_hi;
    @(posedge CLK_I) disable iff (!RST_B_I) cap_hi_w |=> timer8_cap_hi_q == $past(TIMER8_COUNT_I);
  endproperty
  a_cap_hi: assert property (p_cap_hi) else $error("High-time capture missed.");

  property p_cap_lo;
    @(posedge CLK_I) disable iff (!RST_B_I) cap_lo_w |=> timer8_cap_lo_q == $past(TIMER8_COUNT_I);
  endproperty
  a_cap_lo: assert property (p_cap_lo) else $error("Low-time capture missed.");

  property p_cap16_hi;
    @(posedge CLK_I) disable iff (!RST_B_I) cap_any_w |=> timer16_cap_hi_q == $past(TIMER16_COUNT_I[15:8]);
  endproperty
  a_cap16_hi: assert property (p_cap16_hi) else $error("Sixteen-bit high byte wrong.");

  property p_cap16_lo;
    @(posedge CLK_I) disable iff (!RST_B_I) cap_any_w |=> timer16_cap_lo_q == $past(TIMER16_COUNT_I[7:0]);
  endproperty
  a_cap16_lo: assert property (p_cap16_lo) else $error("Sixteen-bit low byte wrong.");

  property p_cap_ro;
    @(posedge CLK_I) disable iff (!RST_B_I)
      (REG_WR_I && REG_ADDR_I == `TCH_OFS_TIMER8_CAP_HI && !cap_hi_w) |=> $stable(timer8_cap_hi_q);
  endproperty
  a_cap_ro: assert property (p_cap_ro) else $error("Write changed a capture register.");

  property p_load_val;
    @(posedge CLK_I) disable iff (!RST_B_I)
      load_w |=> TIMER16_LOAD_O && TIMER16_LOAD_VALUE_O == {$past(timer16_hi_hold_q), $past(timer16_lo_hold_q)};
  endproperty
  a_load_val: assert property (p_load_val) else $error("Load value differs from hold bytes.");

  property p_load_hold;
    @(posedge CLK_I) disable iff (!RST_B_I) !load_w |=> $stable(TIMER16_LOAD_VALUE_O);
  endproperty
  a_load_hold: assert property (p_load_hold) else $error("Load value moved without a load.");

  property p_lvl_sep;
    @(posedge CLK_I) disable iff (!RST_B_I)
      wr_timer8_lo |=> TIMER8_LOW_LEVEL_O == $past(REG_WDATA_I) && $stable(TIMER8_HIGH_LEVEL_O);
  endproperty
  a_lvl_sep: assert property (p_lvl_sep) else $error("Level hold registers not separate.");

  property p_irq;
    @(posedge CLK_I) disable iff (!RST_B_I) CAPTURE_IRQ_O |-> $past(cap_any_w) && $past(CAPTURE_INT_MASK_I);
  endproperty
  a_irq: assert property (p_irq) else $error("Interrupt without masked-in capture.");

  property p_read;
    @(posedge CLK_I) disable iff (!RST_B_I)
      (REG_RD_I && REG_ADDR_I == `TCH_OFS_TIMER16_HI_HOLD && !wr_timer16_hi) |=> REG_RDATA_O == timer16_hi_hold_q;
  endproperty
  a_read: assert property (p_read) else $error("Read answer not ready in one cycle.");

  c_cap_hi: cover property (@(posedge CLK_I) disable iff (!RST_B_I) cap_hi_w);
  c_cap_lo: cover property (@(posedge CLK_I) disable iff (!RST_B_I) cap_lo_w ##[1:50] cap_hi_w);
  c_modulo: cover property (@(posedge CLK_I) disable iff (!RST_B_I) TIMER16_TERMINAL_I && TIMER16_MODULO_I && load_w);
  c_irq:    cover property (@(posedge CLK_I) disable iff (!RST_B_I) CAPTURE_IRQ_O);
endmodule

// ---- bench/tch_pulse_src.sv ----
module tch_pulse_src (
  // Clock.
  input  wire logic clk_i,
  // Commands from the bench.
  input  wire logic sel_b_i,
  input  wire logic lvl_i,
  input  wire logic noise_i,
  // Demodulator pins.
  output logic      pin_a_o,
  output logic      pin_b_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic toggle_q;

  // Pattern that changes every cycle while noise_i is set, so a pin that is not watched never looks quiet.
  initial toggle_q = 1'b0;
  always @(posedge clk_i) begin
    toggle_q <= noise_i ? ~toggle_q : 1'b0;
  end

  // The watched pin carries the commanded level and the other one the noise.
  assign pin_a_o = sel_b_i ? toggle_q : lvl_i;
  assign pin_b_o = sel_b_i ? lvl_i : toggle_q;
endmodule

// ---- bench/tch_capture_hold_tb.sv ----
`include "tch_consts.svh"
module tch_capture_hold_tb;
  import tch_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_b = 0, wr_s = 0, rd_s = 0, mode = 0, sel_b = 0, mask = 0;
  logic en = 0, modn = 0, term = 0, lvl = 0, noise = 0, pin_a, pin_b, load, irq;
  logic [1:0] edge_sel = 2'h0;
  tch_addr_t addr = 4'h0;
  tch_byte_t wdata = 8'h00, rdata, cnt8 = 8'h00, hi_lvl, lo_lvl, e_cap_hi = 8'h00, e_cap_lo = 8'h00;
  logic [15:0] cnt16 = 16'h0000, load_val, e_c16 = 16'h0000;
  int miscompares = 0, checked = 0, irq_cnt = 0;

  tch_capture_hold tch_capture_hold_i (.CLK_I(clk), .RST_B_I(rst_b), .REG_ADDR_I(addr), .REG_WR_I(wr_s),
    .REG_RD_I(rd_s), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .DEMOD_MODE_I(mode), .DEMOD_SEL_B_I(sel_b),
    .EDGE_SEL_I(edge_sel), .CAPTURE_INT_MASK_I(mask), .TIMER8_COUNT_I(cnt8), .TIMER16_COUNT_I(cnt16),
    .TIMER16_ENABLE_I(en), .TIMER16_MODULO_I(modn), .TIMER16_TERMINAL_I(term),
    .TIMER16_LOAD_VALUE_O(load_val), .TIMER16_LOAD_O(load), .TIMER8_HIGH_LEVEL_O(hi_lvl),
    .TIMER8_LOW_LEVEL_O(lo_lvl), .DEMOD_PIN_A_I(pin_a), .DEMOD_PIN_B_I(pin_b), .CAPTURE_IRQ_O(irq));
  tch_pulse_src tch_pulse_src_i (.clk_i(clk), .sel_b_i(sel_b), .lvl_i(lvl), .noise_i(noise),
    .pin_a_o(pin_a), .pin_b_o(pin_b));

  // Free running clock and a count of interrupt pulses.
  always #5 clk = ~clk;
  always @(posedge clk) begin
    if (irq === 1'b1) irq_cnt++;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compare, verdict and bus tasks.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("Counts: %0d compares, %0d mismatches", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input tch_addr_t a, input tch_byte_t d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr_s = 1'b1;
    @(negedge clk);
    wr_s = 1'b0;
  endtask
  task automatic rdc(input tch_addr_t a, input tch_byte_t exp);
    @(negedge clk);
    addr = a;
    rd_s = 1'b1;
    @(negedge clk);
    rd_s = 1'b0;
    chk(rdata, exp);
  endtask
  task automatic chk_caps;
    rdc(`TCH_OFS_TIMER8_CAP_HI, e_cap_hi);
    rdc(`TCH_OFS_TIMER8_CAP_LO, e_cap_lo);
    rdc(`TCH_OFS_TIMER16_CAP_HI, e_c16[15:8]);
    rdc(`TCH_OFS_TIMER16_CAP_LO, e_c16[7:0]);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_reset;
    for (int a = 4; a < 12; a++) rdc(a[3:0], `TCH_RST_BYTE);
    chk({load, irq}, 16'h0000);
    $display("test reset done");
  endtask
  task automatic t_hold;
    wr(`TCH_OFS_TIMER8_LO_HOLD, 8'hA5);
    wr(`TCH_OFS_TIMER8_HI_HOLD, 8'h5A);
    wr(`TCH_OFS_TIMER16_LO_HOLD, 8'h34);
    wr(`TCH_OFS_TIMER16_HI_HOLD, 8'h12);
    rdc(`TCH_OFS_TIMER8_LO_HOLD, 8'hA5);
    rdc(`TCH_OFS_TIMER8_HI_HOLD, 8'h5A);
    rdc(`TCH_OFS_TIMER16_LO_HOLD, 8'h34);
    rdc(`TCH_OFS_TIMER16_HI_HOLD, 8'h12);
    chk({hi_lvl, lo_lvl}, 16'h5AA5);
    rdc(4'h0, `TCH_UNMAPPED);
    rdc(4'hF, `TCH_UNMAPPED);
    $display("test hold done");
  endtask
  task automatic t_load;
    @(negedge clk);
    en = 1'b1;
    @(negedge clk);
    chk({15'h0, load}, 16'h0001);
    chk(load_val, 16'h1234);
    @(negedge clk);
    chk({15'h0, load}, 16'h0000);
    wr(`TCH_OFS_TIMER16_HI_HOLD, 8'h56);
    wr(`TCH_OFS_TIMER16_LO_HOLD, 8'h78);
    chk(load_val, 16'h1234);
    modn = 1'b1;
    term = 1'b1;
    @(negedge clk);
    term = 1'b0;
    chk({15'h0, load}, 16'h0001);
    chk(load_val, 16'h5678);
    modn = 1'b0;
    @(negedge clk);
    term = 1'b1;
    @(negedge clk);
    term = 1'b0;
    chk({15'h0, load}, 16'h0000);
    en = 1'b0;
    $display("test load done");
  endtask
  task automatic edge_pin(input logic l, input logic take, input tch_byte_t c);
    int irq0;
    cnt8 = c;
    cnt16 = {~c, c};
    irq0 = irq_cnt;
    lvl = l;
    repeat (6) @(negedge clk);
    if (take) begin
      if (l) e_cap_lo = c;
      else e_cap_hi = c;
      e_c16 = {~c, c};
    end
    chk(irq_cnt - irq0, {15'h0, take & mask});
    chk_caps;
  endtask
  task automatic t_capture;
    mask = 1'b1;
    for (int e = 0; e < 4; e++) begin
      for (int p = 0; p < 2; p++) begin
        mode = 1'b0;
        noise = 1'b0;
        edge_sel = e[1:0];
        sel_b = p[0];
        repeat (4) @(negedge clk);
        mode = 1'b1;
        noise = 1'b1;
        edge_pin(1'b1, e == 1 || e == 2, 8'h10 + 8'(e * 2 + p));
        edge_pin(1'b0, e == 0 || e == 2, 8'hE0 + 8'(e * 2 + p));
      end
    end
    // Both edges selected, so only the mode bit can refuse this capture.
    mode = 1'b0;
    edge_sel = 2'h2;
    edge_pin(1'b1, 1'b0, 8'hC3);
    mode = 1'b1;
    mask = 1'b0;
    edge_pin(1'b0, 1'b1, 8'h3C);
    for (int a = 8; a < 12; a++) wr(a[3:0], 8'hFF);
    chk_caps;
    $display("test capture done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence and watchdog.
  initial begin
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    t_reset;
    t_hold;
    t_load;
    t_capture;
    test_done;
  end
  initial begin
    #200us;
    miscompares++;
    test_done;
  end
endmodule
